// *** inc/dmc_pkg.sv ***
package dmc_pkg;

    // Register offsets on the plain register port (byte addresses).
    localparam logic [7:0] DMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] DMC_OFF_NDP  = 8'h04;
    localparam logic [7:0] DMC_OFF_SRC  = 8'h08;
    localparam logic [7:0] DMC_OFF_DST  = 8'h0C;
    localparam logic [7:0] DMC_OFF_CNT  = 8'h10;
    localparam logic [7:0] DMC_OFF_MCTL = 8'h14;
    localparam logic [7:0] DMC_OFF_STAT = 8'h18;

    // Field positions in the channel control register.
    localparam int DMC_CTRL_CHAIN   = 9;
    localparam int DMC_CTRL_RUN     = 8;
    localparam int DMC_CTRL_REDUCED = 5;
    localparam int DMC_CTRL_SIZE_LO = 2;
    localparam int DMC_CTRL_DIR     = 1;
    localparam int DMC_CTRL_SINGLE  = 0;

    // Field positions in the controller master control register.
    localparam int DMC_MCTL_RUN_EN = 0;
    localparam int DMC_MCTL_SRST   = 1;

    // Values after reset.
    localparam logic [31:0] DMC_RST_WORD = 32'h0000_0000;
    localparam logic [2:0]  DMC_RST_SIZE = 3'h0;

    // Index of the last descriptor word: reduced load and full load.
    localparam logic [2:0] DMC_LAST_REDUCED = 3'h3;
    localparam logic [2:0] DMC_LAST_FULL    = 3'h7;

    // Depth of the descriptor word buffer.
    localparam int DMC_FIFO_DEPTH = 4;

    // Engine states.
    typedef enum logic [1:0] {DMC_IDLE, DMC_WAIT, DMC_FETCH} dmc_state_t;

    // Bytes moved per bus operation for a beat size code. Large sizes in
    // dual-address mode fall back to four double words.
    function automatic logic [8:0] dmc_beat_bytes(input logic [2:0] code, input logic single);
        case (code)
            3'h0: dmc_beat_bytes = 9'h001;
            3'h1: dmc_beat_bytes = 9'h002;
            3'h2: dmc_beat_bytes = 9'h004;
            3'h3: dmc_beat_bytes = 9'h008;
            3'h4: dmc_beat_bytes = 9'h020;
            3'h5: dmc_beat_bytes = single ? 9'h040 : 9'h020;
            3'h7: dmc_beat_bytes = single ? 9'h100 : 9'h020;
            default: dmc_beat_bytes = 9'h020;
        endcase
    endfunction

endpackage

// *** hdl/dmc_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module dmc_fifo
    import dmc_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = DMC_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // All state of the buffer.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Stored words.
        logic [PW-1:0]               wp;    // Write pointer.
        logic [PW-1:0]               rp;    // Read pointer.
        logic [PW:0]                 cnt;   // Words held.
        logic                        space; // Registered room flag.
    } dmc_fifo_st_t;

    dmc_fifo_st_t s;      // Current state.
    dmc_fifo_st_t next_s; // Next state.
    logic         push;   // A word enters.
    logic         pop;    // A word leaves.

    assign in_ready  = s.space;
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];

    ////////////////////////////////////////////////////////////////////////////
    // Next state: pointers wrap at the depth, the count tracks both sides.
    always_comb begin
        next_s = s;
        push   = in_valid && s.space;
        pop    = out_ready && (s.cnt != '0);
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt   = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
        next_s.space = (next_s.cnt != (PW+1)'(DEPTH));
    end

    // State register; the buffer is empty with room after reset.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s       <= '0;
            s.space <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

endmodule
`default_nettype wire

// *** hdl/dmc_channel.sv ***
// What this block does
// - Chain flag is read-only and shows chaining.
// - Run-enable off or soft reset clears chain.
// - Nonzero pointer write sets chain; zero clears.
// - Chain set loads descriptor; clear stops.
// - Running bit drives transfers; nonzero pointer write sets.
// - Normal end or error clears running bit.
// - Reduced load updates four registers, else eight.
// - Size codes 000-011 give 1,2,4,8 bytes.
// - Codes 100,101,111 give 4,8,32 double words.
// - Large sizes may move other amounts per operation.
// - Direction one memory to I/O, zero reverse.
// - Direction ignored in dual-address mode.
// - Mode bit one single, zero dual; resets zero.
`timescale 1ns/1ns
`default_nettype none
module dmc_channel
    import dmc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             bus_req,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_dst_addr,
    output logic [8:0]       bus_bytes,
    output logic             bus_single,
    output logic             bus_mem_to_io,
    input  wire logic        bus_done,
    input  wire logic        bus_err,
    output logic             desc_req,
    output logic [31:0]      desc_addr,
    input  wire logic        desc_valid,
    input  wire logic [31:0] desc_data,
    output logic             desc_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // All state of the channel in one record.
    typedef struct packed {
        logic             chain;     // Chained operation in progress.
        logic             run;       // Transfer running.
        logic             reduced;   // Reduced descriptor load.
        logic [2:0]       size;      // Beat size code.
        logic             dir;       // Single-address direction.
        logic             single;    // Address mode select.
        logic             run_en;    // Global run enable.
        logic             srst;      // Channel soft reset.
        logic [31:0]      ndp;       // Next descriptor pointer.
        logic [31:0]      src;       // Source pointer.
        logic [31:0]      dst;       // Destination pointer.
        logic [31:0]      cnt;       // Bytes left to move.
        logic [3:0][31:0] aux;       // Remaining descriptor registers.
        dmc_state_t       state;     // Engine state.
        logic [2:0]       word_idx;  // Descriptor word being loaded.
        logic             bus_req;   // Bus operation requested.
        logic [31:0]      bus_addr;  // Source or memory address of the beat.
        logic [31:0]      bus_dst;   // Destination address of the beat.
        logic [8:0]       bus_bytes; // Bytes in the beat.
        logic             bus_sng;   // Beat uses single-address mode.
        logic             bus_m2io;  // Beat moves memory to I/O.
        logic             desc_req;  // Descriptor fetch pulse.
        logic [31:0]      desc_addr; // Address of the descriptor.
        logic [31:0]      rdata;     // Read data for the register port.
    } dmc_st_t;

    dmc_st_t     s;          // Current state.
    dmc_st_t     next_s;     // Next state.
    logic        go;         // Channel allowed to move data.
    logic [8:0]  beat;       // Bytes for the next beat.
    logic [8:0]  sel_bytes;  // Bytes the size code selects.
    logic        take;       // A descriptor word is consumed.
    logic        fifo_valid; // Buffered descriptor word present.
    logic [31:0] fifo_data;  // Buffered descriptor word.
    logic        fifo_ready; // Loader takes the word.

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor words pass a small buffer; the loader only drains it while
    // fetching, so a busy loader pushes back on the fetch side.
    dmc_fifo #(
        .WIDTH (32),
        .DEPTH (DMC_FIFO_DEPTH)
    ) u_desc_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (desc_valid),
        .in_data   (desc_data),
        .in_ready  (desc_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_ready)
    );

    assign fifo_ready = (s.state == DMC_FETCH);
    assign take       = fifo_valid && fifo_ready;

    // Outputs come straight from the state record.
    assign reg_rdata     = s.rdata;
    assign bus_req       = s.bus_req;
    assign bus_addr      = s.bus_addr;
    assign bus_dst_addr  = s.bus_dst;
    assign bus_bytes     = s.bus_bytes;
    assign bus_single    = s.bus_sng;
    assign bus_mem_to_io = s.bus_m2io;
    assign desc_req      = s.desc_req;
    assign desc_addr     = s.desc_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: engine first, then software writes so that a set from
    // software is never lost to a clear from the engine in the same cycle.
    always_comb begin
        next_s          = s;
        next_s.desc_req = 1'b0;
        go              = s.run && s.run_en && !s.srst;
        sel_bytes       = dmc_beat_bytes(s.size, s.single);
        // Large sets are clipped to what is left of the count.
        beat = (s.cnt < {23'h00_0000, sel_bytes}) ? s.cnt[8:0] : sel_bytes;

        // Register read: data stand in the next cycle only.
        next_s.rdata = DMC_RST_WORD;
        if (reg_rd) begin
            case (reg_addr)
                DMC_OFF_CTRL: begin
                    // Bits seven, six and everything above nine read zero.
                    next_s.rdata[DMC_CTRL_CHAIN]   = s.chain;
                    next_s.rdata[DMC_CTRL_RUN]     = s.run;
                    next_s.rdata[DMC_CTRL_REDUCED] = s.reduced;
                    next_s.rdata[DMC_CTRL_SIZE_LO +: 3] = s.size;
                    next_s.rdata[DMC_CTRL_DIR]     = s.dir;
                    next_s.rdata[DMC_CTRL_SINGLE]  = s.single;
                end
                DMC_OFF_NDP:  next_s.rdata = s.ndp;
                DMC_OFF_SRC:  next_s.rdata = s.src;
                DMC_OFF_DST:  next_s.rdata = s.dst;
                DMC_OFF_CNT:  next_s.rdata = s.cnt;
                DMC_OFF_MCTL: begin
                    next_s.rdata[DMC_MCTL_RUN_EN] = s.run_en;
                    next_s.rdata[DMC_MCTL_SRST]   = s.srst;
                end
                DMC_OFF_STAT: begin
                    // Engine status: beat pending, fetching, word buffered.
                    next_s.rdata[0] = s.bus_req;
                    next_s.rdata[1] = (s.state == DMC_FETCH);
                    next_s.rdata[2] = fifo_valid;
                end
                default: next_s.rdata = DMC_RST_WORD;
            endcase
        end

        // Transfer engine.
        case (s.state)
            DMC_IDLE: begin
                if (go && (s.cnt != DMC_RST_WORD)) begin
                    // Issue one beat as the channel registers say.
                    next_s.bus_req   = 1'b1;
                    next_s.bus_bytes = beat;
                    next_s.bus_sng   = s.single;
                    // In single mode the direction picks the memory side.
                    next_s.bus_addr  = (s.single && !s.dir) ? s.dst : s.src;
                    next_s.bus_dst   = s.dst;
                    // Dual mode ignores the direction bit.
                    next_s.bus_m2io  = s.single && s.dir;
                    next_s.state     = DMC_WAIT;
                end else if (go) begin
                    // Count exhausted: chain on or stop.
                    if (s.chain) begin
                        next_s.desc_req  = 1'b1;
                        next_s.desc_addr = s.ndp;
                        next_s.word_idx  = 3'h0;
                        next_s.state     = DMC_FETCH;
                    end else begin
                        next_s.run = 1'b0;
                    end
                end
            end
            DMC_WAIT: begin
                if (bus_err) begin
                    // An error stops the channel at once.
                    next_s.bus_req = 1'b0;
                    next_s.run     = 1'b0;
                    next_s.state   = DMC_IDLE;
                end else if (bus_done) begin
                    next_s.bus_req = 1'b0;
                    next_s.cnt     = s.cnt - {23'h00_0000, s.bus_bytes};
                    // Only the memory side advances in single mode.
                    if (!s.bus_sng || s.bus_m2io) begin
                        next_s.src = s.src + {23'h00_0000, s.bus_bytes};
                    end
                    if (!s.bus_sng || !s.bus_m2io) begin
                        next_s.dst = s.dst + {23'h00_0000, s.bus_bytes};
                    end
                    next_s.state = DMC_IDLE;
                end
            end
            DMC_FETCH: begin
                if (take) begin
                    case (s.word_idx)
                        3'h0: begin
                            // The descriptor rewrites the pointer and the chain flag.
                            next_s.ndp   = fifo_data;
                            next_s.chain = (fifo_data != DMC_RST_WORD);
                        end
                        3'h1: next_s.src = fifo_data;
                        3'h2: next_s.dst = fifo_data;
                        3'h3: next_s.cnt = fifo_data;
                        default: next_s.aux[s.word_idx[1:0]] = fifo_data;
                    endcase
                    // Reduced load stops after four words.
                    if (s.word_idx == (s.reduced ? DMC_LAST_REDUCED : DMC_LAST_FULL)) begin
                        next_s.word_idx = 3'h0;
                        next_s.state    = DMC_IDLE;
                    end else begin
                        next_s.word_idx = s.word_idx + 3'h1;
                    end
                end
            end
            default: next_s.state = DMC_IDLE;
        endcase

        // Software writes.
        if (reg_wr) begin
            case (reg_addr)
                DMC_OFF_CTRL: begin
                    // The chain flag and reserved bits ignore writes.
                    next_s.run     = reg_wdata[DMC_CTRL_RUN];
                    next_s.reduced = reg_wdata[DMC_CTRL_REDUCED];
                    next_s.size    = reg_wdata[DMC_CTRL_SIZE_LO +: 3];
                    next_s.dir     = reg_wdata[DMC_CTRL_DIR];
                    next_s.single  = reg_wdata[DMC_CTRL_SINGLE];
                end
                DMC_OFF_NDP: begin
                    next_s.ndp = reg_wdata;
                    if (reg_wdata != DMC_RST_WORD) begin
                        next_s.chain = 1'b1;
                        next_s.run   = 1'b1;
                    end else begin
                        next_s.chain = 1'b0;
                    end
                end
                DMC_OFF_SRC: next_s.src = reg_wdata;
                DMC_OFF_DST: next_s.dst = reg_wdata;
                DMC_OFF_CNT: next_s.cnt = reg_wdata;
                DMC_OFF_MCTL: begin
                    next_s.run_en = reg_wdata[DMC_MCTL_RUN_EN];
                    next_s.srst   = reg_wdata[DMC_MCTL_SRST];
                end
                default: next_s.srst = next_s.srst;
            endcase
        end

        // Global disable or soft reset drop the chain flag.
        if (!next_s.run_en || next_s.srst) begin
            next_s.chain = 1'b0;
        end
        // Soft reset also abandons any beat or fetch.
        if (next_s.srst) begin
            next_s.run      = 1'b0;
            next_s.bus_req  = 1'b0;
            next_s.word_idx = 3'h0;
            next_s.state    = DMC_IDLE;
        end
    end

    // State register; control state is cleared by reset.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s       <= '0;
            s.size  <= DMC_RST_SIZE;
            s.state <= DMC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the channel's own behaviour.

    // Channel sitting at end of count with chaining on.
    sequence seq_end_chain;
        s.state == DMC_IDLE && s.run && s.run_en && !s.srst && s.cnt == DMC_RST_WORD && s.chain && !reg_wr;
    endsequence

    // Channel sitting at end of count without chaining.
    sequence seq_end_plain;
        s.state == DMC_IDLE && s.run && s.run_en && !s.srst && s.cnt == DMC_RST_WORD && !s.chain && !reg_wr;
    endsequence

    // Last descriptor word being taken.
    sequence seq_last_word;
        take && !reg_wr && s.word_idx == (s.reduced ? DMC_LAST_REDUCED : DMC_LAST_FULL);
    endsequence

    a_chain_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!s.run_en || s.srst) |-> !s.chain)
        else $error("chain flag set while disabled or in soft reset");

    a_ndp_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && reg_addr == DMC_OFF_NDP && reg_wdata != DMC_RST_WORD && s.run_en && !s.srst)
        |=> (s.run && s.chain))
        else $error("nonzero pointer write did not start chaining");

    a_ndp_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && reg_addr == DMC_OFF_NDP && reg_wdata == DMC_RST_WORD) |=> !s.chain)
        else $error("zero pointer write left chain flag set");

    a_chain_fetch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_end_chain |=> (s.state == DMC_FETCH && s.desc_req && s.desc_addr == $past(s.ndp)))
        else $error("chained end did not fetch descriptor");

    a_plain_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_end_plain |=> (!s.run && s.state == DMC_IDLE && !s.bus_req))
        else $error("unchained end did not stop channel");

    a_error_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s.state == DMC_WAIT && bus_err && !reg_wr) |=> (!s.run && !s.bus_req) ##1 !s.bus_req)
        else $error("error did not stop channel");

    a_load_length: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seq_last_word |=> (s.state == DMC_IDLE && $stable(s.reduced)))
        else $error("descriptor load length wrong");

    a_reduced_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s.state == DMC_FETCH && s.reduced) |=> $stable(s.aux))
        else $error("reduced load touched other registers");

    a_beat_size: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($rose(s.bus_req) && !$past(reg_wr) && $past(s.cnt) > 32'h0000_0100)
        |-> s.bus_bytes == dmc_beat_bytes(s.size, s.single))
        else $error("beat size does not match size code");

    a_dual_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($rose(s.bus_req) && !s.bus_sng) |-> (!s.bus_m2io && s.bus_addr == $past(s.src)))
        else $error("direction used in dual-address mode");

    a_single_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($rose(s.bus_req) && s.bus_sng) |-> s.bus_m2io == $past(s.dir))
        else $error("single-address direction wrong");

    a_ctrl_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_rd && reg_addr == DMC_OFF_CTRL)
        |=> (reg_rdata[7:6] == 2'h0 && reg_rdata[DMC_CTRL_CHAIN] == $past(s.chain)))
        else $error("control read shows reserved bits or stale chain flag");

endmodule
`default_nettype wire

// *** test/dmc_bus_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
// Far side: a bus target that answers in one or three cycles by turns, and a descriptor source.
module dmc_bus_partner (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        bus_req,
    input  wire logic        err_mode,
    input  wire logic        desc_req,
    input  wire logic        desc_ready,
    input  wire logic [3:0][31:0] words,
    output logic             bus_done,
    output logic             bus_err,
    output logic             desc_valid,
    output logic [31:0]      desc_data
);
    logic [1:0] wait_cnt; // Cycles already waited on this beat.
    logic       slow;     // Chooses the slow answer for the next beat.
    logic [2:0] idx;      // Next descriptor word; four means none left.
    // Words stand until taken; an idle data line shows the inverse of the last word.
    assign desc_valid = (idx < 3'h4);
    assign desc_data  = desc_valid ? words[idx[1:0]] : ~words[3];
    // One pulse per beat, never while the request is low or already answered.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {bus_done, bus_err, wait_cnt, slow, idx} <= {5'h00, 3'h4};
        end else begin
            {bus_done, bus_err, wait_cnt} <= 4'h0;
            if (bus_req && !bus_done && !bus_err && wait_cnt != {slow, 1'b0}) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else if (bus_req && !bus_done && !bus_err) begin
                {bus_done, bus_err, slow} <= {!err_mode, err_mode, !slow};
            end
            idx <= desc_req ? 3'h0 : idx + {2'h0, desc_valid && desc_ready};
        end
    end
endmodule
`default_nettype wire

// *** test/dmc_channel_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module dmc_channel_bench import dmc_pkg::*; ;
    logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, err_mode = 1'b0, sng;
    logic        bus_req, bus_single, bus_mem_to_io, bus_done, bus_err, desc_req, desc_valid, desc_ready;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, bus_addr, bus_dst_addr, desc_addr, desc_data, d, seen;
    logic [3:0][31:0] words = {32'h0000_0008, 32'h0000_3000, 32'h0000_2000, 32'h0000_0000};
    logic [8:0]  bus_bytes, exp_b;
    logic [2:0]  code;
    int          err_total = 0, samples_checked = 0, n, beats = 0, b0;
    // Clock, a record of the last descriptor address fetched, and a count of answered beats.
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (desc_req === 1'b1) seen <= desc_addr;
    always @(posedge clk_sys) if (bus_done === 1'b1 || bus_err === 1'b1) beats <= beats + 1;
    dmc_channel uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_addr(bus_addr), .bus_dst_addr(bus_dst_addr),
        .bus_bytes(bus_bytes), .bus_single(bus_single), .bus_mem_to_io(bus_mem_to_io), .bus_done(bus_done),
        .bus_err(bus_err), .desc_req(desc_req), .desc_addr(desc_addr), .desc_valid(desc_valid),
        .desc_data(desc_data), .desc_ready(desc_ready));
    dmc_bus_partner far (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .err_mode(err_mode), .words(words),
        .desc_req(desc_req), .desc_ready(desc_ready), .bus_done(bus_done), .bus_err(bus_err),
        .desc_valid(desc_valid), .desc_data(desc_data));
    // One write; an idle cycle follows so a strobe is never assigned twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(negedge clk_sys) d = reg_rdata;
        @(posedge clk_sys);
        `CHK(d, e)
    endtask
    // Bounded wait until the beat request shows level l, returning at a rising edge.
    task automatic wait_req(input logic l);
        n = 0;
        do @(negedge clk_sys); while (bus_req !== l && ++n < 50);
        // A request that never comes or never goes counts as a mismatch.
        if (n == 50) begin
            err_total++;
            $display("[FAIL] %0t beat request stuck", $time);
        end
        @(posedge clk_sys);
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog for a hung handshake.
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rc(DMC_OFF_CTRL, 32'h0000_0000);
        wr(DMC_OFF_CTRL, 32'hFFFF_FFFF);
        rc(DMC_OFF_CTRL, 32'h0000_013F);
        rc(8'h40, 32'h0000_0000);
        wr(DMC_OFF_CTRL, 32'h0000_0000);
        wr(DMC_OFF_MCTL, 32'h0000_0001);
        wr(DMC_OFF_CNT, 32'h0000_1000);
        // Every size code each mode allows, direction from the low code bit; each run stops after one beat.
        for (int i = 0; i < 16; i++) begin
            {sng, code} = i[3:0];
            // Software keeps codes 101 and 111 to single-address mode.
            if (!sng && code[2] && code[0]) continue;
            exp_b = (code < 3'h4) ? 9'h001 << code : (code == 3'h5) ? 9'h040 : (code == 3'h7) ? 9'h100 : 9'h020;
            wr(DMC_OFF_SRC, 32'h0000_1000);
            wr(DMC_OFF_DST, 32'h0000_8000);
            wr(DMC_OFF_CTRL, {22'h0, 2'b01, 3'h0, code, code[0], sng});
            wait_req(1'b1);
            `CHK(bus_bytes, exp_b)
            `CHK(bus_addr, (sng && !code[0]) ? 32'h0000_8000 : 32'h0000_1000)
            `CHK(bus_dst_addr, 32'h0000_8000)
            `CHK(bus_single, sng)
            `CHK(bus_mem_to_io, sng & code[0])
            wr(DMC_OFF_CTRL, {22'h0, 2'b00, 3'h0, code, code[0], sng});
            wait_req(1'b0);
        end
        // A pointer write starts a chained run: one beat, a reduced descriptor, two more beats, then a stop.
        b0 = beats;
        wr(DMC_OFF_CNT, 32'h0000_0004);
        wr(DMC_OFF_CTRL, 32'h0000_0028);
        wr(DMC_OFF_NDP, 32'h0000_0100);
        rc(DMC_OFF_CTRL, 32'h0000_0328);
        repeat (60) @(posedge clk_sys);
        `CHK(beats - b0, 3)
        `CHK(seen, 32'h0000_0100)
        rc(DMC_OFF_CTRL, 32'h0000_0028);
        rc(DMC_OFF_SRC, 32'h0000_2008);
        rc(DMC_OFF_DST, 32'h0000_3008);
        rc(DMC_OFF_NDP, 32'h0000_0000);
        // A failed beat ends the run.
        err_mode <= 1'b1;
        wr(DMC_OFF_CNT, 32'h0000_0010);
        wr(DMC_OFF_CTRL, 32'h0000_0108);
        wait_req(1'b1);
        wait_req(1'b0);
        rc(DMC_OFF_CTRL, 32'h0000_0008);
        // A zero pointer and run enable off each clear the chain flag; soft reset clears the running bit.
        err_mode <= 1'b0;
        wr(DMC_OFF_CNT, 32'h0000_0100);
        wr(DMC_OFF_NDP, 32'h0000_0300);
        wr(DMC_OFF_NDP, 32'h0000_0000);
        rc(DMC_OFF_CTRL, 32'h0000_0108);
        wr(DMC_OFF_NDP, 32'h0000_0300);
        wr(DMC_OFF_MCTL, 32'h0000_0000);
        rc(DMC_OFF_CTRL, 32'h0000_0108);
        wr(DMC_OFF_MCTL, 32'h0000_0003);
        rc(DMC_OFF_CTRL, 32'h0000_0008);
        rc(DMC_OFF_MCTL, 32'h0000_0003);
        rc(DMC_OFF_STAT, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
